// ===== verilog/uao_core.sv
// Unary ALU operations, decimal adjust and halt with an AXI4-Lite register slave
`timescale 1ns/1ps

// Operation
// - Complement memory byte in place, update zero
// - Complement memory into accumulator, memory kept
// - Low nibble above nine or aux: add six
// - High nibble above nine or carry: add 60
// - Adjust adds one constant 00/06/60/66
// - Decimal adjust changes carry only, overflow sets it
// - Decimal adjust result goes to memory
// - Decrement memory byte in place, update zero
// - Decrement memory into accumulator, memory kept
// - Halt stops execution and system clock
// - Halt keeps memory, accumulator, result and the zero, carry and aux flags intact
// - Halt clears watchdog counter and prescaler
// - Halt sets power down, clears timeout only
// - Increment memory byte in place
module uao_core
   import uao_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire logic         reset,
   input  wire uao_axi_req_s axi_req,
   output uao_axi_rsp_s      axi_rsp,
   input  wire logic         wake_up,
   output logic              sys_clk_en,
   output logic              halted
);

   typedef struct packed
   {
      logic                        aw_got;
      logic [7:0]                  aw_addr;
      logic                        w_got;
      logic [31:0]                 w_data;
      logic [3:0]                  w_strb;
      logic                        bvalid;
      logic [1:0]                  bresp;
      logic                        rvalid;
      logic [31:0]                 rdata;
      logic [1:0]                  rresp;
      logic [7:0]                  accumulator_reg;
      logic                        zero_flag;
      logic                        carry_flag;
      logic                        auxiliary_carry_flag;
      logic                        power_down_flag;
      logic                        watchdog_timeout_flag;
      logic [7:0]                  prescaler;
      logic [7:0]                  watchdog_counter;
      logic [7:0]                  result;
      logic                        halted;
      logic [UAO_MEM_DEPTH-1:0][7:0] mem;
   } uao_state_s;

   uao_state_s state_q;
   uao_state_s state_d;

   function automatic logic is_mem(input logic [7:0] addr);
      is_mem = (addr & UAO_MEM_MASK) == UAO_OFS_MEM;
   endfunction

   function automatic logic [3:0] mem_idx(input logic [7:0] addr);
      mem_idx = addr[5:2];
   endfunction

   function automatic logic is_mapped(input logic [7:0] addr);
      is_mapped = is_mem(addr) || addr == UAO_OFS_CTRL || addr == UAO_OFS_ACCUM
                  || addr == UAO_OFS_STATUS || addr == UAO_OFS_WDOG || addr == UAO_OFS_RESULT;
   endfunction

   logic       presc_tick;
   logic       wdt_expire;
   logic       do_write;
   logic [7:0] w_addr;
   logic       lane0;
   uao_op_e    op;
   logic [3:0] op_addr;
   logic [7:0] operand;
   logic [7:0] daj_adj;
   logic [8:0] daj_sum;
   logic       low_fix;
   logic       high_fix;
   logic [7:0] alu_out;
   logic       exec;

   always_comb
   begin
      state_d = state_q;

      // Write address and data are taken in either order, one write at a time
      if (axi_rsp.awready && axi_req.awvalid)
      begin
         state_d.aw_got  = 1'b1;
         state_d.aw_addr = axi_req.awaddr;
      end
      if (axi_rsp.wready && axi_req.wvalid)
      begin
         state_d.w_got  = 1'b1;
         state_d.w_data = axi_req.wdata;
         state_d.w_strb = axi_req.wstrb;
      end
      if (state_q.bvalid && axi_req.bready)
      begin
         state_d.bvalid = 1'b0;
      end

      do_write = state_q.aw_got && state_q.w_got && !state_q.bvalid;
      w_addr   = state_q.aw_addr;
      lane0    = state_q.w_strb[0];
      op       = uao_op_e'(state_q.w_data[UAO_CTRL_OP_LSB +: 3]);
      op_addr  = state_q.w_data[UAO_CTRL_ADDR_LSB +: 4];
      operand  = state_q.mem[op_addr];
      exec     = do_write && lane0 && w_addr == UAO_OFS_CTRL && !state_q.halted;

      low_fix  = state_q.accumulator_reg[3:0] > UAO_BCD_MAX || state_q.auxiliary_carry_flag;
      high_fix = state_q.accumulator_reg[7:4] > UAO_BCD_MAX || state_q.carry_flag;
      case ({high_fix, low_fix})
         2'b01:   daj_adj = UAO_ADJ_LOW;
         2'b10:   daj_adj = UAO_ADJ_HIGH;
         2'b11:   daj_adj = UAO_ADJ_BOTH;
         default: daj_adj = UAO_ADJ_NONE;
      endcase
      daj_sum = {1'b0, state_q.accumulator_reg} + {1'b0, daj_adj};

      case (op)
         UAO_OP_INV, UAO_OP_INVA:   alu_out = ~operand;
         UAO_OP_SUB1, UAO_OP_SUB1A: alu_out = operand - 8'h01;
         UAO_OP_ADD1:               alu_out = operand + 8'h01;
         UAO_OP_DAJ:              alu_out = daj_sum[7:0];
         default:                 alu_out = operand;
      endcase

      // Watchdog runs on a prescaled enable
      presc_tick = state_q.prescaler == UAO_PRESC_LAST;
      wdt_expire = presc_tick && state_q.watchdog_counter == UAO_WDT_LAST;
      state_d.prescaler = state_q.prescaler + 8'h01;
      if (presc_tick)
      begin
         state_d.watchdog_counter = state_q.watchdog_counter + 8'h01;
      end

      if (do_write)
      begin
         state_d.aw_got = 1'b0;
         state_d.w_got  = 1'b0;
         state_d.bvalid = 1'b1;
         state_d.bresp  = is_mapped(w_addr) ? UAO_RESP_OKAY : UAO_RESP_SLVERR;
         if (lane0)
         begin
            if (w_addr == UAO_OFS_ACCUM && !state_q.halted)
            begin
               state_d.accumulator_reg = state_q.w_data[7:0];
            end
            if (w_addr == UAO_OFS_STATUS && !state_q.halted)
            begin
               state_d.zero_flag             = state_q.w_data[UAO_ST_ZERO];
               state_d.carry_flag            = state_q.w_data[UAO_ST_CARRY];
               state_d.auxiliary_carry_flag  = state_q.w_data[UAO_ST_AUX];
               state_d.power_down_flag       = state_q.w_data[UAO_ST_PWRDN];
               state_d.watchdog_timeout_flag = state_q.w_data[UAO_ST_TMOUT];
            end
            if (w_addr == UAO_OFS_WDOG)
            begin
               state_d.prescaler        = 8'h00;
               state_d.watchdog_counter = 8'h00;
            end
            // Memory writes are ignored while halted; contents stay readable for inspection
            if (is_mem(w_addr) && !state_q.halted)
            begin
               state_d.mem[mem_idx(w_addr)] = state_q.w_data[7:0];
            end
         end
      end

      if (exec)
      begin
         case (op)
            UAO_OP_INV, UAO_OP_SUB1:
            begin
               state_d.mem[op_addr] = alu_out;
               state_d.zero_flag    = alu_out == 8'h00;
               state_d.result       = alu_out;
            end
            UAO_OP_INVA, UAO_OP_SUB1A:
            begin
               state_d.accumulator_reg = alu_out;
               state_d.zero_flag       = alu_out == 8'h00;
               state_d.result          = alu_out;
            end
            UAO_OP_ADD1:
            begin
               state_d.mem[op_addr] = alu_out;
               state_d.zero_flag    = alu_out == 8'h00;
               state_d.result       = alu_out;
            end
            UAO_OP_DAJ:
            begin
               state_d.mem[op_addr] = alu_out;
               state_d.carry_flag   = high_fix || daj_sum[8];
               state_d.result       = alu_out;
            end
            UAO_OP_HALT:
            begin
               state_d.halted                = 1'b1;
               state_d.prescaler             = 8'h00;
               state_d.watchdog_counter      = 8'h00;
               state_d.power_down_flag       = 1'b1;
               state_d.watchdog_timeout_flag = 1'b0;
            end
            default:
            begin
               state_d.result = state_q.result;
            end
         endcase
      end

      // Timeout event wins over a status write clear in the same cycle, but a halt in that cycle wins over it
      if (wdt_expire && !(exec && op == UAO_OP_HALT))
      begin
         state_d.watchdog_timeout_flag = 1'b1;
         state_d.halted                = 1'b0;
      end
      if (wake_up && state_q.halted)
      begin
         state_d.halted = 1'b0;
      end

      // Reads answer one cycle after acceptance
      if (state_q.rvalid && axi_req.rready)
      begin
         state_d.rvalid = 1'b0;
      end
      if (axi_rsp.arready && axi_req.arvalid)
      begin
         state_d.rvalid = 1'b1;
         state_d.rresp  = is_mapped(axi_req.araddr) ? UAO_RESP_OKAY : UAO_RESP_SLVERR;
         state_d.rdata  = 32'h0000_0000;
         if (is_mem(axi_req.araddr))
         begin
            state_d.rdata[7:0] = state_q.mem[mem_idx(axi_req.araddr)];
         end
         else
         begin
            case (axi_req.araddr)
               UAO_OFS_ACCUM:  state_d.rdata[7:0] = state_q.accumulator_reg;
               UAO_OFS_STATUS: state_d.rdata[4:0] = {state_q.watchdog_timeout_flag, state_q.power_down_flag,
                                                     state_q.auxiliary_carry_flag, state_q.carry_flag,
                                                     state_q.zero_flag};
               UAO_OFS_WDOG:   state_d.rdata[7:0] = state_q.watchdog_counter;
               UAO_OFS_RESULT: state_d.rdata[7:0] = state_q.result;
               default:        state_d.rdata      = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         state_q                 <= '0;
         state_q.accumulator_reg <= UAO_ACC_RST;
         {state_q.watchdog_timeout_flag, state_q.power_down_flag, state_q.auxiliary_carry_flag,
          state_q.carry_flag, state_q.zero_flag} <= UAO_STATUS_RST;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   always_comb
   begin
      axi_rsp.awready = !state_q.aw_got && !state_q.bvalid;
      axi_rsp.wready  = !state_q.w_got && !state_q.bvalid;
      axi_rsp.bvalid  = state_q.bvalid;
      axi_rsp.bresp   = state_q.bresp;
      axi_rsp.arready = !state_q.rvalid;
      axi_rsp.rvalid  = state_q.rvalid;
      axi_rsp.rdata   = state_q.rdata;
      axi_rsp.rresp   = state_q.rresp;
   end

   assign sys_clk_en = !state_q.halted;
   assign halted     = state_q.halted;

endmodule // uao_core

// ===== verilog/uao_pkg.sv
// Package for the unary ALU and halt block: map, fields, opcodes, bus carriers
package uao_pkg;

   localparam logic [7:0] UAO_OFS_CTRL   = 8'h00;
   localparam logic [7:0] UAO_OFS_ACCUM  = 8'h04;
   localparam logic [7:0] UAO_OFS_STATUS = 8'h08;
   localparam logic [7:0] UAO_OFS_WDOG   = 8'h0C;
   localparam logic [7:0] UAO_OFS_RESULT = 8'h10;
   localparam logic [7:0] UAO_OFS_MEM    = 8'h40;
   localparam logic [7:0] UAO_MEM_MASK   = 8'hC0;

   localparam int UAO_MEM_DEPTH = 16;
   localparam int UAO_CTRL_OP_LSB   = 0;
   localparam int UAO_CTRL_ADDR_LSB = 4;

   localparam int UAO_ST_ZERO  = 0;
   localparam int UAO_ST_CARRY = 1;
   localparam int UAO_ST_AUX   = 2;
   localparam int UAO_ST_PWRDN = 3;
   localparam int UAO_ST_TMOUT = 4;

   localparam logic [7:0] UAO_ACC_RST    = 8'h00;
   localparam logic [4:0] UAO_STATUS_RST = 5'h00;
   localparam logic [7:0] UAO_PRESC_LAST = 8'hFF;
   localparam logic [7:0] UAO_WDT_LAST   = 8'hFF;

   localparam logic [3:0] UAO_BCD_MAX   = 4'h9;
   localparam logic [7:0] UAO_ADJ_NONE  = 8'h00;
   localparam logic [7:0] UAO_ADJ_LOW   = 8'h06;
   localparam logic [7:0] UAO_ADJ_HIGH  = 8'h60;
   localparam logic [7:0] UAO_ADJ_BOTH  = 8'h66;

   localparam logic [1:0] UAO_RESP_OKAY   = 2'h0;
   localparam logic [1:0] UAO_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0]
   {
      UAO_OP_NOP  = 3'b000,
      UAO_OP_INV   = 3'b001,
      UAO_OP_INVA  = 3'b010,
      UAO_OP_DAJ   = 3'b011,
      UAO_OP_SUB1  = 3'b100,
      UAO_OP_SUB1A = 3'b101,
      UAO_OP_HALT  = 3'b110,
      UAO_OP_ADD1  = 3'b111
   } uao_op_e;

   typedef struct packed
   {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } uao_axi_req_s;

   typedef struct packed
   {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } uao_axi_rsp_s;

endpackage

// ===== tb/uao_core_sva.sv
// Checker for bus answers and halt behaviour of the unary ALU block
`timescale 1ns/1ps
module uao_core_sva
   import uao_pkg::*;
(
   input wire logic         ref_clk,
   input wire logic         reset,
   input wire uao_axi_req_s axi_req,
   input wire uao_axi_rsp_s axi_rsp,
   input wire logic         wake_up,
   input wire logic         sys_clk_en,
   input wire logic         halted
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic halt_wr;
   logic both_wr;
   assign both_wr = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
   assign halt_wr = both_wr && axi_req.awaddr == UAO_OFS_CTRL && axi_req.wstrb[0] && !halted
                    && axi_req.wdata[2:0] == UAO_OP_HALT;
   property p_clk_stop; sys_clk_en != halted; endproperty
   a_clk_stop: assert property (p_clk_stop) else $error("clock enable disagrees with halt");
   property p_halt_entry; halt_wr |-> ##[1:3] halted; endproperty
   a_halt_entry: assert property (p_halt_entry) else $error("halt write did not halt");
   property p_wake; halted && wake_up |-> ##[1:2] !halted; endproperty
   a_wake: assert property (p_wake) else $error("wake request ignored");
   property p_wr_answer; both_wr |-> ##[1:2] axi_rsp.bvalid; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
   property p_rd_answer; axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read data missing");
   property p_b_hold; axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_r_hold; axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data changed before taken");
   property p_err_zero; axi_rsp.rvalid && axi_rsp.rresp == UAO_RESP_SLVERR |-> axi_rsp.rdata == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("error read returned data");
endmodule // uao_core_sva

bind uao_core uao_core_sva u_sva (.ref_clk(ref_clk), .reset(reset), .axi_req(axi_req), .axi_rsp(axi_rsp),
   .wake_up(wake_up), .sys_clk_en(sys_clk_en), .halted(halted));

// ===== tb/test_unary_alu_ops_and_halt.sv
// Register-level bench for the unary ALU and halt block
`timescale 1ns/1ps
module test_unary_alu_ops_and_halt
   import uao_pkg::*;
;
   logic         ref_clk = 1'b0;
   logic         reset = 1'b1;
   logic         wake_up = 1'b0;
   uao_axi_req_s req = '0;
   uao_axi_rsp_s rsp;
   logic         sys_clk_en;
   logic         halted;
   int           err_count = 0;
   int           check_count = 0;
   logic [31:0]  rd;
   logic [1:0]   rs;
   always #4 ref_clk = ~ref_clk;
   uao_core u_dut (.ref_clk(ref_clk), .reset(reset), .axi_req(req), .axi_rsp(rsp), .wake_up(wake_up),
      .sys_clk_en(sys_clk_en), .halted(halted));
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_hit = 1'b0;
      logic w_hit = 1'b0;
      @(posedge ref_clk);
      req.awaddr  <= a;
      req.wdata   <= d;
      req.wstrb   <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid  <= 1'b1;
      do
      begin
         @(negedge ref_clk);
         aw_hit = aw_hit | rsp.awready;
         w_hit  = w_hit | rsp.wready;
         @(posedge ref_clk);
         if (aw_hit) req.awvalid <= 1'b0;
         if (w_hit) req.wvalid <= 1'b0;
      end
      while (!(aw_hit && w_hit));
      do @(negedge ref_clk); while (rsp.bvalid !== 1'b1);
      rs = rsp.bresp;
      @(posedge ref_clk);
      req.bready <= 1'b1;
      @(posedge ref_clk);
      req.bready <= 1'b0;
   endtask
   task automatic rd32(input logic [7:0] a);
      logic hit;
      @(posedge ref_clk);
      req.araddr  <= a;
      req.arvalid <= 1'b1;
      do
      begin
         @(negedge ref_clk);
         hit = rsp.arready;
         @(posedge ref_clk);
      end
      while (hit !== 1'b1);
      req.arvalid <= 1'b0;
      do @(negedge ref_clk); while (rsp.rvalid !== 1'b1);
      rd = rsp.rdata;
      rs = rsp.rresp;
      @(posedge ref_clk);
      req.rready <= 1'b1;
      @(posedge ref_clk);
      req.rready <= 1'b0;
   endtask
   task automatic rc(input string name, input logic [7:0] a, input logic [31:0] exp);
      rd32(a);
      chk(name, exp, rd);
   endtask
   function automatic logic [7:0] ma(input int i);
      return UAO_OFS_MEM + 8'(i * 4);
   endfunction
   task automatic op(input uao_op_e o, input int i);
      wr(UAO_OFS_CTRL, 32'(i << UAO_CTRL_ADDR_LSB) | 32'(o));
   endtask
   // Expected decimal adjust: carry in bit 8, result below
   function automatic logic [8:0] dadj_ref(input logic [7:0] a, input logic c, input logic ac);
      logic [7:0] k;
      logic [8:0] s;
      k = ((a[3:0] > 4'h9 || ac) ? 8'h06 : 8'h00) | ((a[7:4] > 4'h9 || c) ? 8'h60 : 8'h00);
      s = 9'(a) + 9'(k);
      return {s[8] | k[5], s[7:0]};
   endfunction
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      conclude();
   end
   initial
   begin
      logic [8:0] e;
      logic [7:0] da [6] = '{8'h45, 8'h3B, 8'h41, 8'hA2, 8'h12, 8'hAB};
      logic [2:0] df [6] = '{3'h1, 3'h0, 3'h4, 3'h0, 3'h2, 3'h0};
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      rc("accum reset", UAO_OFS_ACCUM, 32'h0);
      rc("status reset", UAO_OFS_STATUS, 32'h0);
      wr(ma(1), 32'h5A);
      op(UAO_OP_INV, 1);
      rc("invert mem", ma(1), 32'hA5);
      rc("invert zero clear", UAO_OFS_STATUS, 32'h0);
      rc("invert result", UAO_OFS_RESULT, 32'hA5);
      wr(ma(1), 32'hFF);
      op(UAO_OP_INV, 1);
      rc("invert zero set", UAO_OFS_STATUS, 32'h1);
      wr(ma(2), 32'h0F);
      op(UAO_OP_INVA, 2);
      rc("invert to accum", UAO_OFS_ACCUM, 32'hF0);
      rc("invert to accum mem", ma(2), 32'h0F);
      wr(ma(3), 32'h00);
      op(UAO_OP_SUB1, 3);
      rc("decrement wrap", ma(3), 32'hFF);
      wr(ma(3), 32'h01);
      op(UAO_OP_SUB1, 3);
      rc("decrement mem", ma(3), 32'h00);
      rc("decrement zero", UAO_OFS_STATUS, 32'h1);
      wr(ma(4), 32'h10);
      op(UAO_OP_SUB1A, 4);
      rc("decrement to accum", UAO_OFS_ACCUM, 32'h0F);
      rc("decrement to accum mem", ma(4), 32'h10);
      wr(ma(5), 32'hFF);
      op(UAO_OP_ADD1, 5);
      rc("increment wrap", ma(5), 32'h00);
      for (int i = 0; i < 6; i++)
      begin
         e = dadj_ref(da[i], df[i][1], df[i][2]);
         wr(UAO_OFS_ACCUM, 32'(da[i]));
         wr(UAO_OFS_STATUS, 32'(df[i]));
         op(UAO_OP_DAJ, 6);
         rc("adjust mem", ma(6), 32'(e[7:0]));
         rc("adjust flags", UAO_OFS_STATUS, 32'({df[i][2], e[8], df[i][0]}));
         rc("adjust accum", UAO_OFS_ACCUM, 32'(da[i]));
      end
      // Let the watchdog count up so that the clear on halt shows
      repeat (600) @(posedge ref_clk);
      wr(ma(7), 32'h3C);
      wr(UAO_OFS_STATUS, 32'h11);
      op(UAO_OP_HALT, 0);
      chk("halted", 32'h1, 32'(halted));
      chk("clock stopped", 32'h0, 32'(sys_clk_en));
      rc("halt flags", UAO_OFS_STATUS, 32'h09);
      rc("halt watchdog", UAO_OFS_WDOG, 32'h0);
      wr(ma(7), 32'h00);
      rc("halt mem kept", ma(7), 32'h3C);
      rc("halt accum kept", UAO_OFS_ACCUM, 32'(da[5]));
      wake_up <= 1'b1;
      @(posedge ref_clk);
      wake_up <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("woken", 32'h1, 32'(sys_clk_en));
      rc("unmapped data", 8'h20, 32'h0);
      chk("unmapped resp", 32'(UAO_RESP_SLVERR), 32'(rs));
      wr(8'h20, 32'h1);
      chk("unmapped write resp", 32'(UAO_RESP_SLVERR), 32'(rs));
      wr(UAO_OFS_WDOG, 32'h0);
      chk("watchdog write resp", 32'(UAO_RESP_OKAY), 32'(rs));
      rc("watchdog cleared", UAO_OFS_WDOG, 32'h0);
      conclude();
   end
endmodule // test_unary_alu_ops_and_halt
